// file: verilog/ddr_qos_defs.svh
// register offsets, field positions, reset values and timing figures of the qos/traffic block
`ifndef DDR_QOS_DEFS_SVH
`define DDR_QOS_DEFS_SVH

// ----------------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------------
`define OFS_MON_WINDOW   8'h7C
`define OFS_TALLY0       8'h80
`define OFS_TALLY1       8'h84
`define OFS_TALLY2       8'h88
`define OFS_TALLY3       8'h8C
`define OFS_PREFETCH     8'hA0
`define OFS_PWR_WAIT     8'hA8
`define OFS_CKE_WAIT     8'hAC
`define OFS_LIMIT_CTRL   8'hB0
`define OFS_LIMITS       8'hB4
`define OFS_WLIMITS      8'hBC
`define OFS_WARB_SETUP   8'hC4
`define OFS_BLOCK_CTRL   8'hCC

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PF_BOUNDED_BIT   15
`define PF_AMT_HI        12
`define PF_AMT_LO        8
`define WAIT_HI          19
`define LIM_EN_BIT       0
`define LIM_PER_HI       2
`define LIM_PER_LO       1
`define LIM_SPLIT_BIT    3
`define WARB_CNT_HI      28
`define WARB_CNT_LO      24
`define WARB_KEEP_HI     11
`define WARB_KEEP_LO     8
`define WARB_HIPRI_HI    3
`define WARB_HIPRI_LO    0
`define CTL_MON_EN_BIT   0
`define CTL_CHEN_HI      4
`define CTL_CHEN_LO      1
`define CTL_INDEP_BIT    5
`define CTL_GROUP_BIT    6
`define CTL_DDR3_BIT     7
`define CTL_INIT_GO_BIT  8
`define CTL_STAT_LO      16

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RST_WORD         32'h0000_0000
`define LIM_BASE_PERIOD  13'h0200
`define LIM_UNIT_SHIFT   3
`define LIM_CNT_MAX      11'h7FF

`endif

// file: verilog/ddr_qos_pkg.sv
// types shared by the qos/traffic block and its bench
package ddr_qos_pkg;

  typedef enum logic [3:0] {
    INIT_IDLE       = 4'b0001,
    INIT_WAIT_RESET = 4'b0010,
    INIT_WAIT_CKE   = 4'b0100,
    INIT_READY      = 4'b1000
  } init_state_t;

  // one-cycle pulses from the command scheduler, one bit per channel
  typedef struct packed {
    logic [3:0] rd;
    logic [3:0] wr;
  } cmd_events_t;

  typedef struct packed {
    logic [3:0] req;
    logic [3:0] last;
  } write_req_t;

  typedef struct packed {
    logic start;
    logic term;
    logic data_arrive;
  } prefetch_in_t;

endpackage

// file: verilog/ddr_channel_qos_traffic_ctrl.sv
// traffic monitor, incr prefetch, power-up wait, qos limiter and write arbiter
//
// Contract
// - countdown drops by one each enabled cycle
// - count per-channel commands while countdown nonzero
// - tallies count only with monitor and channel on
// - writing countdown clears all four tallies
// - bounded prefetch issues exactly amount plus one
// - unbounded prefetch runs until early termination
// - reissue after data arrives, outstanding below limit
// - bit 15 selects bounded or unbounded prefetch
// - prefetch amount field v means v+1
// - wait programmed cycles before releasing sdram reset
// - ddr3 waits programmed cycles before clock enable
// - limiter enable bit and four period lengths
// - split bit separates read and write limits
// - zero limit unlimited, n means n times 8
// - write limits one byte per channel
// - write arbitration setup needs independent arbitration bit
// - write group grant allows at most v+1
// - kept channels' write bursts are never broken
// - mask bits place channels in high group
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "ddr_qos_defs.svh"

module ddr_channel_qos_traffic_ctrl
  import ddr_qos_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire cmd_events_t  cmd_issued,
  input  wire prefetch_in_t pf_in,
  output logic              rd_cmd_valid,
  input  wire logic         rd_cmd_ready,
  input  wire write_req_t   wr_in,
  output logic [3:0]        wr_grant,
  output logic [3:0]        rd_block,
  output logic [3:0]        wr_block,
  output logic              sdram_reset_n,
  output logic              sdram_cke
);

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  logic [31:0]  mon_window_q;
  logic [31:0]  tally_q [4];
  logic [31:0]  prefetch_q;
  logic [31:0]  pwr_wait_q;
  logic [31:0]  cke_wait_q;
  logic [31:0]  limit_ctrl_q;
  logic [31:0]  limits_q;
  logic [31:0]  wlimits_q;
  logic [31:0]  warb_q;
  logic [31:0]  block_ctrl_q;
  logic [31:0]  prdata_q;
  logic [31:0]  rdata_d;
  logic         mapped;
  logic         ro_hit;
  logic         acc;
  logic         wr_en;

  assign acc     = psel & penable;
  assign wr_en   = acc & pwrite & clk_en & mapped & ~ro_hit;
  assign pready  = clk_en;
  assign pslverr = acc & clk_en & (~mapped | (pwrite & ro_hit));
  assign prdata  = prdata_q;

  // --------------------------------------------------------------------------
  // derived controls
  // --------------------------------------------------------------------------
  logic        mon_en;
  logic [3:0]  chan_en;
  logic        indep_arb;
  logic        group_arb;
  logic        ddr3_mode;
  logic        pf_bounded;
  logic [5:0]  pf_limit;
  logic        lim_en;
  logic        lim_split;
  logic [1:0]  lim_period;

  assign mon_en     = block_ctrl_q[`CTL_MON_EN_BIT];
  assign chan_en    = block_ctrl_q[`CTL_CHEN_HI:`CTL_CHEN_LO];
  assign indep_arb  = block_ctrl_q[`CTL_INDEP_BIT];
  assign group_arb  = block_ctrl_q[`CTL_GROUP_BIT];
  assign ddr3_mode  = block_ctrl_q[`CTL_DDR3_BIT];
  assign pf_bounded = prefetch_q[`PF_BOUNDED_BIT];
  assign pf_limit   = {1'b0, prefetch_q[`PF_AMT_HI:`PF_AMT_LO]} + 6'h01;
  assign lim_en     = limit_ctrl_q[`LIM_EN_BIT];
  assign lim_split  = limit_ctrl_q[`LIM_SPLIT_BIT];
  assign lim_period = limit_ctrl_q[`LIM_PER_HI:`LIM_PER_LO];

  // --------------------------------------------------------------------------
  // apb decode and read mux
  // --------------------------------------------------------------------------
  init_state_t  init_q;
  logic         pf_busy_q;
  logic         init_go;

  assign init_go = wr_en & (paddr == `OFS_BLOCK_CTRL) & pwdata[`CTL_INIT_GO_BIT];

  always_comb begin
    rdata_d = `RST_WORD;
    mapped  = 1'b1;
    ro_hit  = 1'b0;
    case (paddr)
      `OFS_MON_WINDOW: rdata_d = mon_window_q;
      `OFS_TALLY0: begin
        rdata_d = tally_q[0];
        ro_hit  = 1'b1;
      end
      `OFS_TALLY1: begin
        rdata_d = tally_q[1];
        ro_hit  = 1'b1;
      end
      `OFS_TALLY2: begin
        rdata_d = tally_q[2];
        ro_hit  = 1'b1;
      end
      `OFS_TALLY3: begin
        rdata_d = tally_q[3];
        ro_hit  = 1'b1;
      end
      `OFS_PREFETCH:   rdata_d = prefetch_q;
      `OFS_PWR_WAIT:   rdata_d = pwr_wait_q;
      `OFS_CKE_WAIT:   rdata_d = cke_wait_q;
      `OFS_LIMIT_CTRL: rdata_d = limit_ctrl_q;
      `OFS_LIMITS:     rdata_d = limits_q;
      `OFS_WLIMITS:    rdata_d = wlimits_q;
      `OFS_WARB_SETUP: rdata_d = warb_q;
      `OFS_BLOCK_CTRL: begin
        rdata_d = block_ctrl_q;
        rdata_d[`CTL_STAT_LO +: 6] = {pf_busy_q, sdram_cke, init_q};
      end
      default: mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup phase so the access needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `RST_WORD;
    end else if (clk_en && psel && !penable) begin
      prdata_q <= pwrite ? `RST_WORD : rdata_d;
    end
  end

  // reserved bits are masked on write so they read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_q   <= `RST_WORD;
      pwr_wait_q   <= `RST_WORD;
      cke_wait_q   <= `RST_WORD;
      limit_ctrl_q <= `RST_WORD;
      limits_q     <= `RST_WORD;
      wlimits_q    <= `RST_WORD;
      warb_q       <= `RST_WORD;
      block_ctrl_q <= `RST_WORD;
    end else if (wr_en) begin
      case (paddr)
        `OFS_PREFETCH:   prefetch_q   <= pwdata & 32'h0000_9F00;
        `OFS_PWR_WAIT:   pwr_wait_q   <= pwdata & 32'h000F_FFFF;
        `OFS_CKE_WAIT:   cke_wait_q   <= pwdata & 32'h000F_FFFF;
        `OFS_LIMIT_CTRL: limit_ctrl_q <= pwdata & 32'h0000_000F;
        `OFS_LIMITS:     limits_q     <= pwdata;
        `OFS_WLIMITS:    wlimits_q    <= pwdata;
        `OFS_WARB_SETUP: warb_q       <= pwdata & 32'h1F00_0F0F;
        `OFS_BLOCK_CTRL: block_ctrl_q <= pwdata & 32'h0000_00FF;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // traffic monitor
  // --------------------------------------------------------------------------
  logic win_write;
  logic win_live;

  assign win_write = wr_en & (paddr == `OFS_MON_WINDOW);
  assign win_live  = mon_en & (mon_window_q != 32'h0000_0000);

  // a software write wins over the decrement in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_window_q <= `RST_WORD;
    end else if (clk_en) begin
      if (win_write) begin
        mon_window_q <= pwdata;
      end else if (win_live) begin
        mon_window_q <= mon_window_q - 32'h0000_0001;
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_tally
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tally_q[i] <= `RST_WORD;
      end else if (clk_en) begin
        if (win_write) begin
          tally_q[i] <= `RST_WORD;
        end else if (win_live && chan_en[i] && (cmd_issued.rd[i] || cmd_issued.wr[i])) begin
          tally_q[i] <= tally_q[i] + 32'h0000_0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // channel 1 incr read prefetch
  // --------------------------------------------------------------------------
  logic [5:0] pf_issued_q;
  logic [5:0] pf_out_q;
  logic       pf_fire;
  logic       pf_room;

  // bounded mode meters total issued, unbounded meters commands in flight
  assign pf_room      = pf_bounded ? (pf_issued_q < pf_limit) : (pf_out_q < pf_limit);
  assign rd_cmd_valid = pf_busy_q & pf_room;
  assign pf_fire      = rd_cmd_valid & rd_cmd_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_busy_q   <= 1'b0;
      pf_issued_q <= 6'h00;
    end else if (clk_en) begin
      if (!pf_busy_q) begin
        pf_busy_q   <= pf_in.start;
        pf_issued_q <= 6'h00;
      end else begin
        if (pf_fire) begin
          pf_issued_q <= pf_issued_q + 6'h01;
        end
        if (pf_bounded && pf_fire && (pf_issued_q + 6'h01 == pf_limit)) begin
          pf_busy_q <= 1'b0;
        end else if (!pf_bounded && pf_in.term) begin
          pf_busy_q <= 1'b0;
        end
      end
    end
  end

  // in-flight reads keep draining after the burst is over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_out_q <= 6'h00;
    end else if (clk_en) begin
      if (pf_fire && !(pf_in.data_arrive && pf_out_q != 6'h00)) begin
        pf_out_q <= pf_out_q + 6'h01;
      end else if (!pf_fire && pf_in.data_arrive && pf_out_q != 6'h00) begin
        pf_out_q <= pf_out_q - 6'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // sdram power-up sequencing
  // --------------------------------------------------------------------------
  logic [19:0] init_cnt_q;
  logic        init_cnt_done;

  always_comb begin
    case (init_q)
      INIT_WAIT_RESET: init_cnt_done = (init_cnt_q >= pwr_wait_q[`WAIT_HI:0]);
      INIT_WAIT_CKE:   init_cnt_done = (init_cnt_q >= cke_wait_q[`WAIT_HI:0]);
      default:         init_cnt_done = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q     <= INIT_IDLE;
      init_cnt_q <= 20'h00000;
    end else if (clk_en) begin
      init_cnt_q <= init_cnt_q + 20'h00001;
      case (init_q)
        INIT_IDLE: begin
          init_cnt_q <= 20'h00000;
          if (init_go) begin
            init_q <= INIT_WAIT_RESET;
          end
        end
        INIT_WAIT_RESET: begin
          if (init_cnt_done) begin
            init_cnt_q <= 20'h00000;
            init_q     <= ddr3_mode ? INIT_WAIT_CKE : INIT_READY;
          end
        end
        INIT_WAIT_CKE: begin
          if (init_cnt_done) begin
            init_q <= INIT_READY;
          end
        end
        INIT_READY: init_cnt_q <= 20'h00000;
        default:    init_q <= INIT_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdram_reset_n <= 1'b0;
      sdram_cke     <= 1'b0;
    end else if (clk_en) begin
      sdram_reset_n <= (init_q == INIT_WAIT_CKE) || (init_q == INIT_READY);
      sdram_cke     <= (init_q == INIT_READY);
    end
  end

  // --------------------------------------------------------------------------
  // qos command limiter
  // --------------------------------------------------------------------------
  logic [11:0] per_cnt_q;
  logic [12:0] per_len;
  logic        per_end;

  assign per_len = `LIM_BASE_PERIOD << lim_period;
  assign per_end = ({1'b0, per_cnt_q} == per_len - 13'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 12'h000;
    end else if (clk_en) begin
      per_cnt_q <= (per_end || !lim_en) ? 12'h000 : per_cnt_q + 12'h001;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_limit
    logic [10:0] rcnt_q;
    logic [10:0] wcnt_q;
    logic [7:0]  rlim;
    logic [7:0]  wlim;
    logic [1:0]  radd;
    logic        rover;
    logic        wover;

    assign rlim  = limits_q[8*i +: 8];
    assign wlim  = wlimits_q[8*i +: 8];
    // shared mode counts reads and writes against one limit
    assign radd  = lim_split ? {1'b0, cmd_issued.rd[i]}
                             : {1'b0, cmd_issued.rd[i]} + {1'b0, cmd_issued.wr[i]};
    assign rover = (rlim != 8'h00) && (rcnt_q >= {rlim, 3'b000});
    assign wover = (wlim != 8'h00) && (wcnt_q >= {wlim, 3'b000});
    assign rd_block[i] = lim_en & rover;
    assign wr_block[i] = lim_en & (lim_split ? wover : rover);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rcnt_q <= 11'h000;
        wcnt_q <= 11'h000;
      end else if (clk_en) begin
        if (per_end || !lim_en) begin
          rcnt_q <= 11'h000;
          wcnt_q <= 11'h000;
        end else begin
          if (rcnt_q < `LIM_CNT_MAX - 11'h001) begin
            rcnt_q <= rcnt_q + {9'h000, radd};
          end
          if (lim_split && cmd_issued.wr[i] && wcnt_q != `LIM_CNT_MAX) begin
            wcnt_q <= wcnt_q + 11'h001;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // write channel arbiter
  // --------------------------------------------------------------------------
  logic [3:0] grant_q;
  logic [4:0] grant_cnt_q;
  logic [4:0] group_max;
  logic [3:0] keep_eff;
  logic [3:0] hipri_eff;
  logic       group_eff;
  logic [3:0] eligible;
  logic [3:0] pool;
  logic [3:0] pick;
  logic       issued_now;
  logic       last_now;
  logic       release_now;
  logic       done_cmd;

  // setup fields are ignored unless independent arbitration is on
  assign group_eff  = indep_arb & group_arb;
  assign keep_eff   = indep_arb ? warb_q[`WARB_KEEP_HI:`WARB_KEEP_LO] : 4'h0;
  assign hipri_eff  = indep_arb ? warb_q[`WARB_HIPRI_HI:`WARB_HIPRI_LO] : 4'h0;
  assign group_max  = warb_q[`WARB_CNT_HI:`WARB_CNT_LO];
  assign eligible   = wr_in.req & ~wr_block;
  assign pool       = |(eligible & hipri_eff) ? (eligible & hipri_eff) : eligible;
  assign pick       = pool & (~pool + 4'h1);
  assign issued_now = |(cmd_issued.wr & grant_q);
  assign last_now   = |(cmd_issued.wr & grant_q & wr_in.last);

  // a kept burst runs to its last beat even past the group count
  always_comb begin
    if (|(grant_q & keep_eff)) begin
      done_cmd = last_now;
    end else if (group_eff) begin
      done_cmd = issued_now && (grant_cnt_q == group_max);
    end else begin
      done_cmd = issued_now;
    end
  end

  assign release_now = (grant_q != 4'h0) && (done_cmd || !(|(grant_q & wr_in.req)));
  assign wr_grant    = grant_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q     <= 4'h0;
      grant_cnt_q <= 5'h00;
    end else if (clk_en) begin
      if (grant_q == 4'h0 || release_now) begin
        grant_q     <= pick;
        grant_cnt_q <= 5'h00;
      end else if (issued_now && grant_cnt_q != 5'h1F) begin
        grant_cnt_q <= grant_cnt_q + 5'h01;
      end
    end
  end

endmodule

// file: sim/ddr_qos_asserts.sv
// concurrent checks on the ports of the qos/traffic block
`timescale 1ns/1ns
module ddr_qos_asserts
  import ddr_qos_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pslverr,
  input wire cmd_events_t  cmd_issued,
  input wire prefetch_in_t pf_in,
  input wire write_req_t   wr_in,
  input wire logic         rd_cmd_valid,
  input wire logic [3:0]   wr_grant,
  input wire logic [3:0]   rd_block,
  input wire logic [3:0]   wr_block,
  input wire logic         sdram_reset_n,
  input wire logic         sdram_cke
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic lim_set_q;
  assign acc = psel && penable && clk_en;
  // blocking is only legal once software has touched the limiter control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_set_q <= 1'b0;
    end else if (acc && pwrite && paddr == 8'hB0) begin
      lim_set_q <= 1'b1;
    end
  end
  sequence go_write;
    acc && pwrite && paddr == 8'hCC && pwdata[8] && !sdram_reset_n;
  endsequence
  sequence reset_held;
    !sdram_reset_n [*2];
  endsequence
  chk_tally_readonly: assert property (acc && pwrite && paddr[7:4] == 4'h8 |-> pslverr)
    else $error("tally write not refused");
  chk_limit_idle: assert property (!lim_set_q |-> (rd_block | wr_block) == 4'h0)
    else $error("block before limiter set up");
  chk_grant_onehot: assert property ($onehot0(wr_grant))
    else $error("write grant not one-hot");
  chk_grant_has_req: assert property (
    wr_grant != 4'h0 && wr_grant != $past(wr_grant) |-> ($past(wr_in.req) & wr_grant) != 4'h0)
    else $error("grant to idle channel");
  chk_grant_holds: assert property (
    clk_en && wr_grant != 4'h0 && (cmd_issued.wr & wr_grant) == 4'h0
    && (wr_in.req & wr_grant) != 4'h0 |=> $stable(wr_grant))
    else $error("grant dropped without cause");
  chk_cke_after_rst: assert property (sdram_cke |-> sdram_reset_n)
    else $error("clock enable while sdram in reset");
  chk_reset_wait: assert property (go_write |=> reset_held)
    else $error("sdram reset released too soon");
  chk_prefetch_cause: assert property (
    $rose(rd_cmd_valid) |-> $past(pf_in.start || pf_in.data_arrive))
    else $error("read request without cause");
endmodule

// file: sim/sched_model.sv
// command scheduler stand-in: takes prefetch reads, returns their data later
`timescale 1ns/1ns
module sched_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rd_cmd_valid,
  input  wire logic       slow,
  output logic            rd_cmd_ready,
  output logic            data_arrive,
  output logic [7:0]      fires,
  output logic [7:0]      peak
);
  logic [3:0] pipe_q;
  logic [7:0] outst_q;
  logic       fire;
  assign fire = rd_cmd_valid && rd_cmd_ready;
  // fixed four-cycle read latency; oldest data lands first
  assign data_arrive = pipe_q[3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cmd_ready <= 1'b0;
      pipe_q <= 4'h0;
      fires <= 8'h00;
      outst_q <= 8'h00;
      peak <= 8'h00;
    end else begin
      rd_cmd_ready <= slow ? !rd_cmd_ready : 1'b1;
      pipe_q <= {pipe_q[2:0], fire};
      fires <= fires + {7'h00, fire};
      outst_q <= outst_q + {7'h00, fire} - {7'h00, data_arrive};
      if (outst_q > peak) begin
        peak <= outst_q;
      end
    end
  end
endmodule

// file: sim/test_ddr_channel_qos_traffic_ctrl.sv
// bench for the qos/traffic block: apb register tasks and port scenarios
`timescale 1ns/1ns
module test_ddr_channel_qos_traffic_ctrl;
  import ddr_qos_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, slow, start, term;
  logic rd_cmd_valid, rd_cmd_ready, data_arrive, sdram_reset_n, sdram_cke, rerr;
  logic [7:0]   paddr, fires, peak, b;
  logic [31:0]  pwdata, prdata, rdat, r1;
  logic [3:0]   wr_grant, rd_block, wr_block;
  cmd_events_t  cmd_issued;
  write_req_t   wr_in;
  prefetch_in_t pf_in;
  int           checked, miscompares, n;
  logic [7:0]   ofs [8] = '{8'h7C, 8'hA0, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hBC, 8'hC4};
  logic [31:0]  msk [8] = '{32'hFFFFFFFF, 32'h00009F00, 32'h000FFFFF, 32'h000FFFFF,
                           32'h0000000F, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1F000F0F};
  assign pf_in = {start, term, data_arrive};
  ddr_channel_qos_traffic_ctrl ddr_channel_qos_traffic_ctrl_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_issued(cmd_issued), .pf_in(pf_in), .rd_cmd_valid(rd_cmd_valid),
    .rd_cmd_ready(rd_cmd_ready), .wr_in(wr_in), .wr_grant(wr_grant), .rd_block(rd_block),
    .wr_block(wr_block), .sdram_reset_n(sdram_reset_n), .sdram_cke(sdram_cke));
  sched_model sched_model_i (.pclk(pclk), .presetn(presetn), .rd_cmd_valid(rd_cmd_valid),
    .slow(slow), .rd_cmd_ready(rd_cmd_ready), .data_arrive(data_arrive), .fires(fires),
    .peak(peak));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end
  task automatic results();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // one-cycle command pulse, then one cycle for its effect to settle
  task automatic ev(input logic [7:0] v);
    @(posedge pclk);
    cmd_issued <= cmd_events_t'(v);
    @(posedge pclk);
    cmd_issued <= 8'h00;
    @(posedge pclk);
  endtask
  task automatic pulse_pf(input logic s);
    @(posedge pclk);
    if (s) start <= 1'b1;
    else term <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    term <= 1'b0;
  endtask
  task automatic wait_hi(ref logic sig);
    n = 0;
    while (sig !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      results();
    end
  endtask
  initial begin
    {presetn, clk_en, psel, penable, pwrite, slow, start, term} = 8'b01000000;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd_issued = 8'h00;
    wr_in = 8'h00;
    checked = 0;
    miscompares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ofs[i], 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 32'h0);
    end
    rd(8'hF0, 32'h0);
    chk(rerr, 1'b1);
    // monitor: ch0 and ch1 enabled, ch2 not
    wr(8'hCC, 32'h00000007);
    wr(8'h7C, 32'd100);
    for (int i = 0; i < 7; i++) ev(8'h01 | (i < 2 ? 8'h20 : 8'h00) | (i == 2 ? 8'h22 : 8'h00)
      | (i < 4 ? 8'h04 : 8'h00));
    rd(8'h80, 32'd7);
    rd(8'h84, 32'd3);
    rd(8'h88, 32'd0);
    // a frozen enable must not eat into the window, so the gap stays three
    apb(1'b0, 8'h7C, 32'h0);
    r1 = rdat;
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, 8'h7C, 32'h0);
    chk(r1 - rdat, 32'd3);
    repeat (120) @(posedge pclk);
    rd(8'h7C, 32'd0);
    ev(8'h01);
    rd(8'h80, 32'd7);
    wr(8'h80, 32'h5);
    chk(rerr, 1'b1);
    wr(8'h7C, 32'd5);
    rd(8'h80, 32'd0);
    // prefetch: unbounded with two in flight, then bounded to three
    wr(8'hA0, 32'h00000100);
    b = fires;
    pulse_pf(1'b1);
    repeat (40) @(posedge pclk);
    pulse_pf(1'b0);
    repeat (10) @(posedge pclk);
    chk(peak, 8'd2);
    chk(fires - b > 8'd4, 1'b1);
    chk(rd_cmd_valid, 1'b0);
    wr(8'hA0, 32'h00008200);
    slow <= 1'b1;
    b = fires;
    pulse_pf(1'b1);
    pulse_pf(1'b0);
    repeat (30) @(posedge pclk);
    chk(fires - b, 8'd3);
    // power-up waits of five cycles each
    chk(sdram_reset_n, 1'b0);
    wr(8'hA8, 32'd5);
    wr(8'hAC, 32'd5);
    wr(8'hCC, 32'h00000180);
    wait_hi(sdram_reset_n);
    chk(n >= 5 && n <= 10, 1'b1);
    wait_hi(sdram_cke);
    chk(n >= 5 && n <= 10, 1'b1);
    // limiter: shared count, ch0 limit 8, ch1 unlimited
    wr(8'hB4, 32'h00000001);
    wr(8'hB0, 32'h1);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) chk(wr_block, 4'h0);
      ev(8'h03);
    end
    chk({rd_block, wr_block}, 8'h11);
    repeat (520) @(posedge pclk);
    chk({rd_block, wr_block}, 8'h00);
    wr(8'hB0, 32'h0);
    wr(8'hBC, 32'h00000002);
    wr(8'hB0, 32'h9);
    for (int i = 0; i < 8; i++) ev(8'h10);
    chk({rd_block, wr_block}, 8'h10);
    for (int i = 0; i < 16; i++) begin
      if (i == 15) chk(wr_block, 4'h0);
      ev(8'h01);
    end
    chk(wr_block, 4'h1);
    wr(8'hB0, 32'h0);
    // write arbiter: ch2 high priority
    wr(8'hCC, 32'h0);
    wr(8'hC4, 32'h00000004);
    wr_in <= 8'h50;
    repeat (3) @(posedge pclk);
    chk(wr_grant, 4'h1);
    wr(8'hCC, 32'h20);
    ev(8'h01);
    chk(wr_grant, 4'h4);
    wr(8'hC4, 32'h00000400);
    ev(8'h04);
    chk(wr_grant, 4'h4);
    wr_in <= 8'h10;
    repeat (3) @(posedge pclk);
    chk(wr_grant, 4'h1);
    wr(8'hCC, 32'h60);
    wr(8'hC4, 32'h01000004);
    wr_in <= 8'h50;
    ev(8'h01);
    chk(wr_grant, 4'h1);
    ev(8'h01);
    chk(wr_grant, 4'h4);
    results();
  end
endmodule
bind ddr_channel_qos_traffic_ctrl ddr_qos_asserts ddr_qos_asserts_i (.*);
